// >>> inc/fsp_pkg.sv
// constants and types for the flash self-programming sequencer
// assumes a 20 MHz system clock and a byte-wide register port
package fsp_pkg;

	// register map
	localparam logic [3:0] CTRL_OFS = 4'h0;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] RDATA_NONE = 8'h00;

	// control/status bit positions
	localparam int BIT_EN = 0;
	localparam int BIT_ERS = 1;
	localparam int BIT_WRT = 2;
	localparam int BIT_LCK = 3;
	localparam int BIT_REEN = 4;
	localparam int BIT_BUSY = 6;
	localparam int BIT_IEN = 7;
	localparam int CMD_MSB = 4;

	// command patterns in the low five bits
	localparam logic [4:0] CMD_LOAD = 5'h01;
	localparam logic [4:0] CMD_ERASE = 5'h03;
	localparam logic [4:0] CMD_WRITE = 5'h05;
	localparam logic [4:0] CMD_LOCK = 5'h09;
	localparam logic [4:0] CMD_REEN = 5'h11;
	localparam logic [4:0] CMD_CLEAR = 5'h00;

	// store-program instruction must follow within this many cycles
	localparam logic [2:0] ARM_CYCLES = 3'h4;
	localparam logic [2:0] ARM_LAST = 3'h1;

	// addresses and reset values
	localparam logic [15:0] APP_RESET_ADDR = 16'h0000;
	localparam logic [15:0] ERASED_WORD = 16'hFFFF;
	localparam logic [5:0] LOCK_RESET = 6'h3F;
	localparam int LOCK_MSB = 5;
	localparam int Z_BYTE_BIT = 0;

	// programming time
	localparam int CLK_NS = 50;
	localparam int PROG_MIN_NS = 3700000;
	localparam int PROG_MAX_NS = 4500000;
	localparam int PROG_MIN_CYCLES = (PROG_MIN_NS + CLK_NS - 1) / CLK_NS;
	localparam int PROG_MAX_CYCLES = PROG_MAX_NS / CLK_NS;

	typedef enum {FSP_IDLE, FSP_ARMED, FSP_BUSY} fsp_state_t;
	typedef enum {FSP_OP_NONE, FSP_OP_LOAD, FSP_OP_ERASE, FSP_OP_WRITE,
		FSP_OP_LOCK, FSP_OP_REEN} fsp_op_t;

endpackage

// >>> hdl/fsp_sequencer.sv
// flash self-programming sequencer: commands, page buffer, op timing
// assumes one-cycle spm_exec_i pulses with z_ptr_i and data_pair_i valid
//
// Operation
// - reset vector is 0x0000 with the fuse at 1, boot address with it 0
// - fuses are read-only inputs; the core has no path to change them
// - flash address comes from the 16-bit pointer: word and page fields
// - page address is latched at start; later pointer changes do nothing
// - lock-bit setting ignores the pointer completely
// - program-memory loads address bytes; pointer bit 0 picks the byte
// - buffer loads in any order; erase and write use the same page
// - pattern X0000011 then store within four cycles erases the page
// - concurrent-section ops keep core running; others halt the core
// - pattern 00000001 then store loads one buffer word at word field
// - buffer clears after page write, re-enable, and system reset
// - an EEPROM write during page loading discards loaded buffer data
// - pattern X0000101 then store writes the page; data pair ignored
// - enabled interrupt stays asserted while the enable bit is clear
// - erase and write block concurrent-section reads and set busy flag
// - pattern X0001001 then store programs lock bits where data is zero
// - lock-bit programming blocks nothing and halts nothing
// - EEPROM write blocks all self-programming and fuse/lock reads
// - enable and command bits lapse if no store follows in four cycles
// - erase, write and lock operations last between 3.7 and 4.5 ms
// - busy flag reads one while the concurrent section is blocked
//
// The address map and the plain strobed port were decided locally.
`timescale 1ns/1ps
`default_nettype none

module fsp_sequencer #(
	parameter int WORD_BITS = 6,
	parameter int NCS_FIRST_PAGE = 448,
	parameter logic [15:0] BOOT_RESET_ADDR = 16'h3800,
	parameter int PROG_CYCLES = fsp_pkg::PROG_MIN_CYCLES
) (
	input wire logic clk_sys_i,
	input wire logic reset_i,
	input wire logic [3:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [7:0] reg_rdata_o,
	input wire logic spm_exec_i,
	input wire logic [15:0] z_ptr_i,
	input wire logic [15:0] data_pair_i,
	input wire logic eeprom_write_active_i,
	input wire logic boot_reset_select_fuse_i,
	output logic [15:0] reset_vector_o,
	output logic [14:0] lpm_word_addr_o,
	output logic lpm_byte_sel_o,
	input wire logic [WORD_BITS-1:0] page_buf_rd_idx_i,
	output logic [15:0] page_buf_rd_data_o,
	output logic flash_erase_o,
	output logic flash_write_o,
	output logic [14-WORD_BITS:0] flash_page_o,
	output logic [5:0] lock_bits_o,
	output logic concurrent_section_busy_o,
	output logic cpu_halt_o,
	output logic fuse_read_block_o,
	output logic irq_o
);

	localparam int PAGE_WORDS = 1 << WORD_BITS;
	localparam int PAGE_BITS = 15 - WORD_BITS;
	localparam int TW = $clog2(PROG_CYCLES + 1);
	localparam logic [TW-1:0] TIMER_LOAD = TW'(PROG_CYCLES - 1);
	localparam logic [TW-1:0] TIMER_ZERO = '0;
	localparam logic [PAGE_BITS-1:0] NCS_PAGE = PAGE_BITS'(NCS_FIRST_PAGE);
	fsp_pkg::fsp_state_t state;
	fsp_pkg::fsp_op_t op_kind, exec_op;
	logic [4:0] cmd_bits;
	logic int_enable, section_busy, op_concurrent, vector_taken;
	logic [2:0] arm_cnt;
	logic [TW-1:0] timer;
	logic [PAGE_BITS-1:0] op_page;
	logic [5:0] lock_data, lock_bits;
	logic [15:0] buf_mem [PAGE_WORDS];
	logic [PAGE_WORDS-1:0] buf_valid;
	logic ctrl_wr, cmd_wr, exec_ok, op_start, op_done, buf_clear;
	logic [WORD_BITS-1:0] z_word;
	logic [PAGE_BITS-1:0] z_page;
	// command bits map to one operation; anything else does nothing
	function automatic fsp_pkg::fsp_op_t fsp_decode(input logic [4:0] cmd);
		case (cmd)
			fsp_pkg::CMD_LOAD: fsp_decode = fsp_pkg::FSP_OP_LOAD;
			fsp_pkg::CMD_ERASE: fsp_decode = fsp_pkg::FSP_OP_ERASE;
			fsp_pkg::CMD_WRITE: fsp_decode = fsp_pkg::FSP_OP_WRITE;
			fsp_pkg::CMD_LOCK: fsp_decode = fsp_pkg::FSP_OP_LOCK;
			fsp_pkg::CMD_REEN: fsp_decode = fsp_pkg::FSP_OP_REEN;
			default: fsp_decode = fsp_pkg::FSP_OP_NONE;
		endcase
	endfunction

	// pointer split: word within page and page number
	assign z_word = z_ptr_i[WORD_BITS:1];
	assign z_page = z_ptr_i[15:WORD_BITS+1];

	// an EEPROM write shuts out both the command-bit write and the instruction
	assign ctrl_wr = reg_wr_i && (reg_addr_i == fsp_pkg::CTRL_OFS);
	assign cmd_wr = ctrl_wr && (state != fsp_pkg::FSP_BUSY)
		&& !eeprom_write_active_i;
	assign exec_ok = (state == fsp_pkg::FSP_ARMED) && spm_exec_i
		&& !eeprom_write_active_i;
	assign exec_op = fsp_decode(cmd_bits);
	assign op_start = exec_ok && (exec_op == fsp_pkg::FSP_OP_ERASE
		|| exec_op == fsp_pkg::FSP_OP_WRITE
		|| exec_op == fsp_pkg::FSP_OP_LOCK);
	assign op_done = (state == fsp_pkg::FSP_BUSY) && (timer == TIMER_ZERO);

	// buffer wipe: page write done, re-enable, or EEPROM write mid-load
	assign buf_clear = (op_done && op_kind == fsp_pkg::FSP_OP_WRITE)
		|| (exec_ok && exec_op == fsp_pkg::FSP_OP_REEN)
		|| (eeprom_write_active_i && (buf_valid != '0));

	// sequencer: idle, waiting for the instruction, or timing an operation
	always_ff @(posedge clk_sys_i)
	begin
		if (reset_i)
		begin
			state <= fsp_pkg::FSP_IDLE;
			arm_cnt <= '0;
			timer <= TIMER_ZERO;
		end
		else
		begin
			case (state)
				fsp_pkg::FSP_IDLE:
				begin
					if (cmd_wr && reg_wdata_i[fsp_pkg::BIT_EN])
					begin
						state <= fsp_pkg::FSP_ARMED;
						arm_cnt <= fsp_pkg::ARM_CYCLES;
					end
				end
				fsp_pkg::FSP_ARMED:
				begin
					if (op_start)
					begin
						state <= fsp_pkg::FSP_BUSY;
						timer <= TIMER_LOAD;
					end
					else if (exec_ok)
						state <= fsp_pkg::FSP_IDLE;
					else if (cmd_wr && reg_wdata_i[fsp_pkg::BIT_EN])
						arm_cnt <= fsp_pkg::ARM_CYCLES;
					else if (cmd_wr || arm_cnt == fsp_pkg::ARM_LAST)
						state <= fsp_pkg::FSP_IDLE;
					else
						arm_cnt <= arm_cnt - 3'h1;
				end
				fsp_pkg::FSP_BUSY:
				begin
					// timed on the system clock: a new rate needs new PROG_CYCLES
					if (op_done)
						state <= fsp_pkg::FSP_IDLE;
					else
						timer <= timer - TW'(1);
				end
				default: state <= fsp_pkg::FSP_IDLE;
			endcase
		end
	end

	// command bits: set by software, cleared on lapse or completion
	always_ff @(posedge clk_sys_i)
	begin
		if (reset_i)
			cmd_bits <= fsp_pkg::CMD_CLEAR;
		else if (op_done)
			cmd_bits <= fsp_pkg::CMD_CLEAR;
		else if (cmd_wr && reg_wdata_i[fsp_pkg::BIT_EN])
			cmd_bits <= reg_wdata_i[fsp_pkg::CMD_MSB:0];
		else if (cmd_wr)
			cmd_bits <= fsp_pkg::CMD_CLEAR;
		else if (exec_ok && !op_start)
			cmd_bits <= fsp_pkg::CMD_CLEAR;
		else if (state == fsp_pkg::FSP_ARMED && !exec_ok
			&& arm_cnt == fsp_pkg::ARM_LAST)
			cmd_bits <= fsp_pkg::CMD_CLEAR;
	end

	// interrupt enable is writable at any time, even while busy
	always_ff @(posedge clk_sys_i)
	begin
		if (reset_i)
			int_enable <= fsp_pkg::CTRL_RESET[fsp_pkg::BIT_IEN];
		else if (ctrl_wr)
			int_enable <= reg_wdata_i[fsp_pkg::BIT_IEN];
	end

	// busy flag: set at erase/write start, cleared only by re-enable
	always_ff @(posedge clk_sys_i)
	begin
		if (reset_i)
			section_busy <= fsp_pkg::CTRL_RESET[fsp_pkg::BIT_BUSY];
		else if (op_start && exec_op != fsp_pkg::FSP_OP_LOCK)
			section_busy <= 1'b1;
		else if (exec_ok && exec_op == fsp_pkg::FSP_OP_REEN)
			section_busy <= 1'b0;
	end

	// operation latch: the pointer is free for other use once started
	always_ff @(posedge clk_sys_i)
	begin
		if (reset_i)
		begin
			op_kind <= fsp_pkg::FSP_OP_NONE;
			op_page <= '0;
			op_concurrent <= 1'b0;
			lock_data <= fsp_pkg::LOCK_RESET;
		end
		else if (op_start)
		begin
			op_kind <= exec_op;
			if (exec_op == fsp_pkg::FSP_OP_LOCK)
				lock_data <= data_pair_i[fsp_pkg::LOCK_MSB:0];
			else
			begin
				op_page <= z_page;
				op_concurrent <= (z_page < NCS_PAGE);
			end
		end
	end

	// lock bits only ever go from one to zero
	always_ff @(posedge clk_sys_i)
	begin
		if (reset_i)
			lock_bits <= fsp_pkg::LOCK_RESET;
		else if (op_done && op_kind == fsp_pkg::FSP_OP_LOCK)
			lock_bits <= lock_bits & lock_data;
	end

	// page buffer words; a word never loaded reads as erased flash
	always_ff @(posedge clk_sys_i)
	begin
		if (exec_ok && exec_op == fsp_pkg::FSP_OP_LOAD)
			buf_mem[z_word] <= data_pair_i;
	end

	// a repeated load just overwrites; the array cannot detect it
	always_ff @(posedge clk_sys_i)
	begin
		if (reset_i)
			buf_valid <= '0;
		else if (buf_clear)
			buf_valid <= '0;
		else if (exec_ok && exec_op == fsp_pkg::FSP_OP_LOAD)
			buf_valid[z_word] <= 1'b1;
	end

	// buffer read port for the flash array during a page write
	always_ff @(posedge clk_sys_i)
	begin
		if (reset_i)
			page_buf_rd_data_o <= fsp_pkg::ERASED_WORD;
		else if (buf_valid[page_buf_rd_idx_i])
			page_buf_rd_data_o <= buf_mem[page_buf_rd_idx_i];
		else
			page_buf_rd_data_o <= fsp_pkg::ERASED_WORD;
	end

	// reset vector: fuse sampled once after release, never written back
	always_ff @(posedge clk_sys_i)
	begin
		if (reset_i)
		begin
			vector_taken <= 1'b0;
			reset_vector_o <= fsp_pkg::APP_RESET_ADDR;
		end
		else if (!vector_taken)
		begin
			vector_taken <= 1'b1;
			reset_vector_o <= boot_reset_select_fuse_i
				? fsp_pkg::APP_RESET_ADDR : BOOT_RESET_ADDR;
		end
	end
	// load addressing follows the pointer a cycle late, so needs no reset
	always_ff @(posedge clk_sys_i)
	begin
		lpm_word_addr_o <= z_ptr_i[15:1];
		lpm_byte_sel_o <= z_ptr_i[fsp_pkg::Z_BYTE_BIT];
	end
	// register read data, valid in the cycle after the strobe only
	always_ff @(posedge clk_sys_i)
	begin
		if (reset_i)
			reg_rdata_o <= fsp_pkg::RDATA_NONE;
		else if (reg_rd_i && reg_addr_i == fsp_pkg::CTRL_OFS)
			reg_rdata_o <= {int_enable, section_busy, 1'b0,
				cmd_bits};
		else
			reg_rdata_o <= fsp_pkg::RDATA_NONE;
	end

	// flash array controls and status derived from the latched operation
	assign flash_erase_o = (state == fsp_pkg::FSP_BUSY)
		&& (op_kind == fsp_pkg::FSP_OP_ERASE);
	assign flash_write_o = (state == fsp_pkg::FSP_BUSY)
		&& (op_kind == fsp_pkg::FSP_OP_WRITE);
	assign flash_page_o = op_page;
	assign lock_bits_o = lock_bits;
	assign concurrent_section_busy_o = section_busy;
	assign cpu_halt_o = (flash_erase_o || flash_write_o)
		&& !op_concurrent;
	assign fuse_read_block_o = eeprom_write_active_i;
	assign irq_o = int_enable && !cmd_bits[fsp_pkg::BIT_EN];

	// checks
	logic [TW-1:0] busy_cnt;
	always_ff @(posedge clk_sys_i)
	begin
		if (reset_i || state != fsp_pkg::FSP_BUSY)
			busy_cnt <= '0;
		else
			busy_cnt <= busy_cnt + TW'(1);
	end
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (reset_i);
	sequence arm_s;
		cmd_wr && reg_wdata_i[fsp_pkg::BIT_EN];
	endsequence
	sequence no_store_s;
		(!spm_exec_i && !reg_wr_i) [*4];
	endsequence
	sequence start_erase_write_s;
		op_start && exec_op != fsp_pkg::FSP_OP_LOCK;
	endsequence
	arm_lapse_a: assert property (arm_s ##1 no_store_s |=>
		!cmd_bits[fsp_pkg::BIT_EN] && state == fsp_pkg::FSP_IDLE)
		else $error("command did not lapse after four cycles");
	op_length_a: assert property (op_done |->
		busy_cnt == TIMER_LOAD)
		else $error("operation length differs from programming time");
	done_clear_a: assert property (op_done |=>
		!cmd_bits[fsp_pkg::BIT_EN] && (irq_o == int_enable))
		else $error("enable bit not cleared at completion");
	busy_block_a: assert property (start_erase_write_s |=>
		concurrent_section_busy_o throughout
		(state == fsp_pkg::FSP_BUSY) [*2])
		else $error("busy flag not held during erase or write");
	lock_free_a: assert property (op_start &&
		exec_op == fsp_pkg::FSP_OP_LOCK |=> !cpu_halt_o &&
		$stable(concurrent_section_busy_o))
		else $error("lock programming blocked or halted");
	page_latch_a: assert property ((state == fsp_pkg::FSP_BUSY) &&
		$past(state == fsp_pkg::FSP_BUSY) |-> $stable(flash_page_o))
		else $error("page address changed during operation");
	// the buffer may be wiped by the EEPROM write, but never loaded
	ee_block_a: assert property (state == fsp_pkg::FSP_ARMED &&
		spm_exec_i && eeprom_write_active_i |=> state != fsp_pkg::FSP_BUSY
		&& (buf_valid & ~$past(buf_valid)) == '0)
		else $error("self-programming ran during an EEPROM write");
	halt_ncs_a: assert property ((start_erase_write_s and
		(z_page >= NCS_PAGE)) |=> cpu_halt_o [*2])
		else $error("core not halted for no-concurrent section");
	reen_clear_a: assert property (exec_ok &&
		exec_op == fsp_pkg::FSP_OP_REEN |=> buf_valid == '0 &&
		!concurrent_section_busy_o)
		else $error("re-enable did not clear buffer and busy flag");

endmodule // fsp_sequencer

`default_nettype wire

// >>> test/fsp_core_model.sv
// core model: drives the register port and store-program pulses
// assumes the bench calls its tasks one at a time from one process
`timescale 1ns/1ps
`default_nettype none

module fsp_core_model (
	input wire logic clk_sys_i,
	input wire logic ee_busy_i,
	input wire logic [7:0] rdata_i,
	output logic [3:0] addr_o,
	output logic [7:0] wdata_o,
	output logic wr_o,
	output logic rd_o,
	output logic spm_o,
	output logic [15:0] z_o,
	output logic [15:0] data_o
);
	// idle bus at time zero
	initial
	begin
		addr_o = 4'h0;
		wdata_o = 8'h00;
		wr_o = 1'b0;
		rd_o = 1'b0;
		spm_o = 1'b0;
		z_o = 16'h0000;
		data_o = 16'h0000;
	end

	// released data lines flip so stale values never look valid
	task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
		@(posedge clk_sys_i);
		addr_o <= a;
		wdata_o <= v;
		wr_o <= 1'b1;
		@(posedge clk_sys_i);
		wr_o <= 1'b0;
		wdata_o <= ~v;
	endtask

	// read data stands only in the cycle after the strobe
	task automatic rd_reg(input logic [3:0] a, output logic [7:0] v);
		@(posedge clk_sys_i);
		addr_o <= a;
		rd_o <= 1'b1;
		@(posedge clk_sys_i);
		rd_o <= 1'b0;
		#1 v = rdata_i;
	endtask

	// pointer moves without a store, as a load or other use would
	task automatic point(input logic [15:0] z);
		z_o <= z;
	endtask

	// one store-program pulse after gap idle cycles
	task automatic spm(input int gap, input logic [15:0] z,
		input logic [15:0] d);
		repeat (gap) @(posedge clk_sys_i);
		spm_o <= 1'b1;
		z_o <= z;
		data_o <= d;
		@(posedge clk_sys_i);
		spm_o <= 1'b0;
		data_o <= ~d;
	endtask

	// arming write then store; waits out any eeprom write first
	task automatic cmd(input logic [7:0] v, input int gap,
		input logic [15:0] z, input logic [15:0] d);
		while (ee_busy_i) @(posedge clk_sys_i);
		wr_reg(4'h0, v);
		spm(gap, z, d);
	endtask
endmodule // fsp_core_model

`default_nettype wire

// >>> test/tb.sv
// self-checking bench for the flash self-programming sequencer
// assumes a short PROG_CYCLES so each operation ends quickly
`timescale 1ns/1ps
`default_nettype none

module tb;
	localparam int PROG = 20;
	localparam logic [15:0] BOOT = 16'h3800;
	logic clk_sys_i = 1'b0;
	logic reset_i = 1'b1;
	logic fuse = 1'b1;
	logic ee = 1'b0;
	logic [5:0] idx = 6'h00;
	logic [3:0] a;
	logic [7:0] wd, rdv, r;
	logic wr, rd, spm, lpb, ers, wrt, busy, halt, fblk, irq, h;
	logic [15:0] z, d, vec, bufd;
	logic [14:0] lpa;
	logic [8:0] page;
	logic [5:0] lock;
	int bad_count = 0;
	int total_checks = 0;
	int n;

	// 20 MHz system clock
	always #25 clk_sys_i = ~clk_sys_i;

	fsp_core_model u_core (.clk_sys_i(clk_sys_i), .ee_busy_i(ee),
		.rdata_i(rdv), .addr_o(a), .wdata_o(wd), .wr_o(wr), .rd_o(rd),
		.spm_o(spm), .z_o(z), .data_o(d));

	fsp_sequencer #(.PROG_CYCLES(PROG), .BOOT_RESET_ADDR(BOOT)) u_dut (
		.clk_sys_i(clk_sys_i), .reset_i(reset_i), .reg_addr_i(a),
		.reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdv),
		.spm_exec_i(spm), .z_ptr_i(z), .data_pair_i(d),
		.eeprom_write_active_i(ee), .boot_reset_select_fuse_i(fuse),
		.reset_vector_o(vec), .lpm_word_addr_o(lpa), .lpm_byte_sel_o(lpb),
		.page_buf_rd_idx_i(idx), .page_buf_rd_data_o(bufd),
		.flash_erase_o(ers), .flash_write_o(wrt), .flash_page_o(page),
		.lock_bits_o(lock), .concurrent_section_busy_o(busy),
		.cpu_halt_o(halt), .fuse_read_block_o(fblk), .irq_o(irq));

	task automatic chk(input string nm, input logic [15:0] e,
		input logic [15:0] g);
		total_checks++;
		if (g !== e)
		begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// fuse is only sampled after reset, so it changes inside one
	task automatic do_reset(input logic f);
		@(posedge clk_sys_i);
		reset_i <= 1'b1;
		fuse <= f;
		repeat (10) @(posedge clk_sys_i);
		reset_i <= 1'b0;
		repeat (3) @(posedge clk_sys_i);
		#1;
	endtask

	// buffer read port has one cycle of latency
	task automatic chk_buf(input logic [5:0] i, input logic [15:0] e);
		@(posedge clk_sys_i);
		idx <= i;
		@(posedge clk_sys_i);
		#1;
		chk("buffer word", e, bufd);
	endtask

	// count cycles of a running erase or write and note any halt
	task automatic wait_op(output int cnt, output logic hl);
		cnt = 0;
		hl = 1'b0;
		#1;
		while ((ers | wrt) === 1'b1 && cnt < 200)
		begin
			cnt++;
			hl = hl | halt;
			@(posedge clk_sys_i);
			#1;
		end
	endtask

	task automatic t_reset();
		chk("vector", 16'h0000, vec);
		chk("locks", 16'h003F, {10'h000, lock});
		u_core.point(16'h1235);
		repeat (2) @(posedge clk_sys_i);
		#1;
		chk("lpm word", 16'h091A, {1'b0, lpa});
		chk("lpm byte", 16'h0001, {15'h0000, lpb});
		do_reset(1'b0);
		chk("boot vector", BOOT, vec);
		$display("reset test done");
	endtask

	task automatic t_regs();
		u_core.wr_reg(4'h3, 8'h83);
		u_core.rd_reg(4'h3, r);
		chk("unmapped", 16'h0000, {8'h00, r});
		u_core.wr_reg(4'h0, 8'h03);
		u_core.rd_reg(4'h0, r);
		chk("armed bits", 16'h0003, {8'h00, r});
		u_core.spm(3, 16'h0280, 16'h0000);
		#1;
		chk("late erase", 16'h0000, {15'h0000, ers});
		u_core.rd_reg(4'h0, r);
		chk("lapsed bits", 16'h0000, {8'h00, r});
		$display("register test done");
	endtask

	task automatic t_load();
		u_core.cmd(8'h01, 0, 16'h000A, 16'h1234);
		u_core.cmd(8'h01, 0, 16'h0004, 16'hBEEF);
		chk_buf(6'd5, 16'h1234);
		chk_buf(6'd2, 16'hBEEF);
		chk_buf(6'd0, 16'hFFFF);
		@(posedge clk_sys_i);
		ee <= 1'b1;
		@(posedge clk_sys_i);
		ee <= 1'b0;
		chk_buf(6'd2, 16'hFFFF);
		$display("load test done");
	endtask

	// buffer filled before the erase; store in the last window cycle
	task automatic t_erase();
		u_core.cmd(8'h01, 0, 16'h0286, 16'h5A5A);
		u_core.cmd(8'h83, 3, 16'h02A1, 16'hFFFF);
		u_core.point(16'hFF80);
		wait_op(n, h);
		chk("erase cycles", 16'(PROG), 16'(n));
		chk("erase page", 16'h0005, {7'h00, page});
		chk("erase halt", 16'h0000, {15'h0000, h});
		chk("busy", 16'h0001, {15'h0000, busy});
		chk("irq", 16'h0001, {15'h0000, irq});
		u_core.rd_reg(4'h0, r);
		chk("status", 16'h00C0, {8'h00, r & 8'hC1});
		u_core.cmd(8'h11, 0, 16'h0000, 16'h0000);
		chk_buf(6'd3, 16'hFFFF);
		chk("busy off", 16'h0000, {15'h0000, busy});
		$display("erase test done");
	endtask

	// erase, re-enable, fill, write, on a halting page
	task automatic t_write();
		u_core.cmd(8'h03, 0, 16'hE100, 16'h0000);
		wait_op(n, h);
		chk("ncs halt", 16'h0001, {15'h0000, h});
		u_core.cmd(8'h11, 0, 16'h0000, 16'h0000);
		u_core.cmd(8'h01, 0, 16'hE102, 16'h1357);
		u_core.cmd(8'h05, 0, 16'hE100, 16'h2468);
		wait_op(n, h);
		chk("write cycles", 16'(PROG), 16'(n));
		chk("write halt", 16'h0001, {15'h0000, h});
		chk("write page", 16'h01C2, {7'h00, page});
		chk("busy", 16'h0001, {15'h0000, busy});
		chk("irq off", 16'h0000, {15'h0000, irq});
		chk_buf(6'd1, 16'hFFFF);
		u_core.cmd(8'h11, 0, 16'h0000, 16'h0000);
		$display("write test done");
	endtask

	task automatic t_lock();
		u_core.cmd(8'h09, 0, 16'h1234, 16'h00C5);
		repeat (3) @(posedge clk_sys_i);
		#1;
		chk("lock busy", 16'h0000, {15'h0000, busy});
		chk("lock halt", 16'h0000, {15'h0000, halt});
		repeat (PROG + 5) @(posedge clk_sys_i);
		#1;
		chk("lock bits", 16'h0005, {10'h000, lock});
		$display("lock test done");
	endtask

	// erase armed first, then the EEPROM write starts before the store
	task automatic t_eeprom();
		u_core.wr_reg(4'h0, 8'h03);
		ee <= 1'b1;
		u_core.spm(1, 16'h0280, 16'h0000);
		#1;
		chk("ee erase", 16'h0000, {15'h0000, ers});
		chk("fuse block", 16'h0001, {15'h0000, fblk});
		@(posedge clk_sys_i);
		ee <= 1'b0;
		u_core.rd_reg(4'h0, r);
		chk("ee bits", 16'h0000, {8'h00, r & 8'h1F});
		chk("fuse free", 16'h0000, {15'h0000, fblk});
		$display("eeprom test done");
	endtask

	// main sequence
	initial
	begin
		do_reset(1'b1);
		t_reset();
		t_regs();
		t_load();
		t_erase();
		t_write();
		t_lock();
		t_eeprom();
		wrap_up();
	end

	// watchdog: the whole run needs well under a thousand cycles
	initial
	begin
		#(5000 * 50);
		bad_count++;
		wrap_up();
	end
endmodule // tb

`default_nettype wire
